/* File: pkg/iasg_defines.svh */
// constants for the indirect access and stack guard block
`ifndef IASG_DEFINES_SVH
`define IASG_DEFINES_SVH
// register byte offsets
`define IASG_OFF_PTR0_LO 8'h00
`define IASG_OFF_PTR0_HI 8'h04
`define IASG_OFF_PTR1_LO 8'h08
`define IASG_OFF_PTR1_HI 8'h0c
`define IASG_OFF_CFG 8'h10
`define IASG_OFF_PWR 8'h14
`define IASG_OFF_DEPTH 8'h18
`define IASG_OFF_ISTAT 8'h1c
`define IASG_OFF_IEN 8'h20
`define IASG_OFF_ICLR 8'h24
// field positions
`define IASG_CFG_SFRE_BIT 0
`define IASG_PWR_OVF_BIT 0
`define IASG_PWR_UNF_BIT 1
`define IASG_IRQ_OVF_BIT 0
`define IASG_IRQ_UNF_BIT 1
`define IASG_IRQ_SELF_BIT 2
// reset values
`define IASG_PTR_RST 8'h00
`define IASG_CFG_RST 1'h0
`define IASG_IEN_RST 3'h0
// stack geometry
`define IASG_STACK_LEVELS 5'h10
// indirect port addresses and region bounds
`define IASG_PORT0_ADDR 16'h0000
`define IASG_PORT1_ADDR 16'h0001
`define IASG_LINEAR_BASE 16'h2000
`define IASG_FLASH_BASE 16'h8000
`endif

/* File: pkg/iasg_pkg.sv */
// types for the indirect access and stack guard block
package iasg_pkg;
  // memory region, one-hot
  typedef enum logic [2:0] {
    IASG_REG_BANKED = 3'h1,
    IASG_REG_LINEAR = 3'h2,
    IASG_REG_FLASH = 3'h4
  } iasg_region_t;
  // access to an indirect port from the core
  typedef struct packed {
    logic valid;
    logic sel;
    logic we;
    logic [7:0] wdata;
  } iasg_core_req_t;
  // redirected access to data space
  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
    iasg_region_t region;
  } iasg_mem_req_t;
endpackage : iasg_pkg

/* File: hw/iasg_top.sv */
// indirect access ports, region decode and stack guard
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`include "iasg_defines.svh"

module iasg_top (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // core side
  input wire iasg_pkg::iasg_core_req_t core_req_i,
  output logic [7:0] core_rdata_o,
  output logic core_rvalid_o,
  input wire logic push_i,
  input wire logic pop_i,
  // data space side
  output iasg_pkg::iasg_mem_req_t mem_o,
  input wire logic [7:0] mem_rdata_i,
  // system
  output logic stack_reset_o,
  output logic irq_o
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  // unpacked per channel, so each generate process owns a whole entry
  logic [7:0] pointer_low_byte_r [2]; // per channel
  logic [7:0] pointer_high_byte_r [2]; // per channel
  logic [15:0] pointer_pair [2]; // joined pointers
  logic stack_fault_reset_enable_r; // config bit
  logic stack_overflow_flag_r; // power control
  logic stack_underflow_flag_r; // power control
  logic [4:0] depth_r; // stack levels in use
  logic [2:0] istat_r; // sticky events
  logic [2:0] ien_r; // event enables
  logic [31:0] prdata_r; // read data
  logic [7:0] core_rdata_r; // indirect read data
  logic core_rvalid_r; // read done pulse
  logic stack_reset_r; // fault reset pulse

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire wr_en = psel_i & penable_i & pwrite_i;
  wire setup = psel_i & ~penable_i;
  wire hit_cfg = (paddr_i == `IASG_OFF_CFG);
  wire hit_pwr = (paddr_i == `IASG_OFF_PWR);
  wire hit_dep = (paddr_i == `IASG_OFF_DEPTH);
  wire hit_ist = (paddr_i == `IASG_OFF_ISTAT);
  wire hit_ien = (paddr_i == `IASG_OFF_IEN);
  wire hit_icl = (paddr_i == `IASG_OFF_ICLR);
  wire [3:0] hit_ptr; // lo0, hi0, lo1, hi1
  assign hit_ptr[0] = (paddr_i == `IASG_OFF_PTR0_LO);
  assign hit_ptr[1] = (paddr_i == `IASG_OFF_PTR0_HI);
  assign hit_ptr[2] = (paddr_i == `IASG_OFF_PTR1_LO);
  assign hit_ptr[3] = (paddr_i == `IASG_OFF_PTR1_HI);
  wire mapped = (|hit_ptr) | hit_cfg | hit_pwr | hit_dep
    | hit_ist | hit_ien | hit_icl;

  // zero wait states; unmapped addresses answer an error
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~mapped;
  assign prdata_o = prdata_r;

  // ----------------------------------------
  // pointer registers
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_chan
      // software loads each byte of the pointer
      always_ff @(posedge clock_i) begin
        if (reset_i) begin
          pointer_low_byte_r[g] <= `IASG_PTR_RST;
          pointer_high_byte_r[g] <= `IASG_PTR_RST;
        end else if (wr_en) begin
          if (hit_ptr[2*g]) begin
            pointer_low_byte_r[g] <= pwdata_i[7:0];
          end
          if (hit_ptr[2*g+1]) begin
            pointer_high_byte_r[g] <= pwdata_i[7:0];
          end
        end
      end
      // high byte above low byte
      assign pointer_pair[g] = {pointer_high_byte_r[g],
        pointer_low_byte_r[g]};
    end
  endgenerate

  // ----------------------------------------
  // indirect access path
  // ----------------------------------------
  wire [15:0] ind_addr = pointer_pair[core_req_i.sel];
  // a port pointing at either port hits nothing real
  wire self_hit = (ind_addr == `IASG_PORT0_ADDR)
    | (ind_addr == `IASG_PORT1_ADDR);
  wire ind_req = core_req_i.valid;
  wire ind_rd = ind_req & ~core_req_i.we;

  // region bounds live in their own constants
  wire in_flash = (ind_addr >= `IASG_FLASH_BASE);
  wire in_lin = (ind_addr >= `IASG_LINEAR_BASE) & ~in_flash;
  wire iasg_pkg::iasg_region_t region = in_flash
    ? iasg_pkg::IASG_REG_FLASH
    : (in_lin ? iasg_pkg::IASG_REG_LINEAR
      : iasg_pkg::IASG_REG_BANKED);

  // forward to data space, never to a port register
  assign mem_o.req = ind_req & ~self_hit;
  assign mem_o.we = core_req_i.we & ~self_hit;
  assign mem_o.addr = ind_addr;
  assign mem_o.wdata = core_req_i.wdata;
  assign mem_o.region = region;

  // read data is taken one edge after the request
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      core_rdata_r <= 8'h00;
      core_rvalid_r <= 1'b0;
    end else begin
      core_rvalid_r <= ind_rd;
      if (ind_rd) begin
        // self pointing reads as zero
        core_rdata_r <= self_hit ? 8'h00 : mem_rdata_i;
      end
    end
  end
  assign core_rdata_o = core_rdata_r;
  assign core_rvalid_o = core_rvalid_r;

  // ----------------------------------------
  // stack guard
  // ----------------------------------------
  wire ovf_ev = push_i & ~pop_i
    & (depth_r == `IASG_STACK_LEVELS);
  wire unf_ev = pop_i & ~push_i
    & (depth_r == 5'h00);
  wire fault = (ovf_ev | unf_ev)
    & stack_fault_reset_enable_r;

  // depth follows push and pop; a fault reset empties it
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      depth_r <= 5'h00;
      stack_reset_r <= 1'b0;
    end else begin
      stack_reset_r <= fault;
      if (fault) begin
        depth_r <= 5'h00;
      end else if (push_i & ~pop_i & ~ovf_ev) begin
        depth_r <= depth_r + 5'h01;
      end else if (pop_i & ~push_i & ~unf_ev) begin
        depth_r <= depth_r - 5'h01;
      end
    end
  end
  assign stack_reset_o = stack_reset_r;

  // ----------------------------------------
  // config and power control flags
  // ----------------------------------------
  wire clr_ovf = wr_en & hit_pwr & pwdata_i[`IASG_PWR_OVF_BIT];
  wire clr_unf = wr_en & hit_pwr & pwdata_i[`IASG_PWR_UNF_BIT];

  // flags are write one to clear; a new fault wins over the clear
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      stack_fault_reset_enable_r <= `IASG_CFG_RST;
      stack_overflow_flag_r <= 1'b0;
      stack_underflow_flag_r <= 1'b0;
    end else begin
      if (wr_en & hit_cfg) begin
        stack_fault_reset_enable_r <= pwdata_i[`IASG_CFG_SFRE_BIT];
      end
      stack_overflow_flag_r <= ovf_ev
        | (stack_overflow_flag_r & ~clr_ovf);
      stack_underflow_flag_r <= unf_ev
        | (stack_underflow_flag_r & ~clr_unf);
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  wire [2:0] ev; // event pulses
  assign ev[`IASG_IRQ_OVF_BIT] = ovf_ev;
  assign ev[`IASG_IRQ_UNF_BIT] = unf_ev;
  assign ev[`IASG_IRQ_SELF_BIT] = ind_req & self_hit;
  wire [2:0] iclr = (wr_en & hit_icl) ? pwdata_i[2:0] : 3'h0;

  // sticky status, set beats clear
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      istat_r <= 3'h0;
      ien_r <= `IASG_IEN_RST;
    end else begin
      istat_r <= ev | (istat_r & ~iclr);
      if (wr_en & hit_ien) begin
        ien_r <= pwdata_i[2:0];
      end
    end
  end
  assign irq_o = |(istat_r & ien_r);

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  wire [7:0] ptr_rd = hit_ptr[0] ? pointer_low_byte_r[0]
    : hit_ptr[1] ? pointer_high_byte_r[0]
    : hit_ptr[2] ? pointer_low_byte_r[1]
    : hit_ptr[3] ? pointer_high_byte_r[1] : 8'h00;
  wire [31:0] rd_mux = {24'h0, ptr_rd}
    | (hit_cfg ? {31'h0, stack_fault_reset_enable_r} : 32'h0)
    | (hit_pwr ? {30'h0, stack_underflow_flag_r,
      stack_overflow_flag_r} : 32'h0)
    | (hit_dep ? {27'h0, depth_r} : 32'h0)
    | (hit_ist ? {29'h0, istat_r} : 32'h0)
    | (hit_ien ? {29'h0, ien_r} : 32'h0);

  // captured in the setup cycle, stable through access
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      prdata_r <= 32'h0;
    end else if (setup & ~pwrite_i) begin
      prdata_r <= rd_mux;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  property p_fwd;
    ind_req & ~self_hit |-> mem_o.req
      && mem_o.addr == pointer_pair[core_req_i.sel];
  endproperty
  a_fwd: assert property (p_fwd)
    else $error("indirect access not forwarded");

  property p_self_rd;
    ind_rd & self_hit |=> core_rvalid_o && core_rdata_o == 8'h00;
  endproperty
  a_self_rd: assert property (p_self_rd)
    else $error("self read not zero");

  property p_self_wr;
    ind_req & self_hit |-> ~mem_o.req & ~mem_o.we;
  endproperty
  a_self_wr: assert property (p_self_wr)
    else $error("self write not dropped");

  property p_join;
    ind_req |-> mem_o.addr[15:8] == pointer_high_byte_r[core_req_i.sel]
      && mem_o.addr[7:0] == pointer_low_byte_r[core_req_i.sel];
  endproperty
  a_join: assert property (p_join)
    else $error("pointer bytes misjoined");

  property p_top;
    ind_req && mem_o.addr == 16'hffff |->
      mem_o.region == iasg_pkg::IASG_REG_FLASH;
  endproperty
  a_top: assert property (p_top)
    else $error("top address not reached");

  property p_bank;
    ind_req && mem_o.addr < `IASG_LINEAR_BASE |->
      mem_o.region == iasg_pkg::IASG_REG_BANKED;
  endproperty
  a_bank: assert property (p_bank)
    else $error("bank region wrong");

  property p_ovf_rst;
    push_i & ~pop_i & depth_r == 5'h10
      & stack_fault_reset_enable_r |=> stack_reset_o && depth_r == 5'h00;
  endproperty
  a_ovf_rst: assert property (p_ovf_rst)
    else $error("overflow reset missing");

  property p_unf_rst;
    pop_i & ~push_i & depth_r == 5'h00
      & stack_fault_reset_enable_r |=> stack_reset_o;
  endproperty
  a_unf_rst: assert property (p_unf_rst)
    else $error("underflow reset missing");

  property p_no_rst;
    ~stack_fault_reset_enable_r |=> ~stack_reset_o;
  endproperty
  a_no_rst: assert property (p_no_rst)
    else $error("reset while disabled");

  property p_flags;
    ovf_ev |=> stack_overflow_flag_r;
  endproperty
  a_flags: assert property (p_flags)
    else $error("overflow flag not set");

  property p_unf_flag;
    unf_ev |=> stack_underflow_flag_r;
  endproperty
  a_unf_flag: assert property (p_unf_flag)
    else $error("underflow flag not set");

  c_ovf: cover property (fault ##1 stack_reset_o);
  c_self: cover property (ind_rd & self_hit);
  c_lin: cover property (mem_o.req
    && mem_o.region == iasg_pkg::IASG_REG_LINEAR);
  c_irq: cover property (irq_o);

endmodule : iasg_top

/* File: sim/iasg_bench.sv */
// self-checking bench for the indirect access and stack guard block
`timescale 1ns/1ns
`include "iasg_defines.svh"

module iasg_bench;
  // ----------------------------------------
  // signals facing the design
  // ----------------------------------------
  logic clock_i;
  logic reset_i;
  logic psel_i, penable_i, pwrite_i;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o;
  iasg_pkg::iasg_core_req_t core_req_i;
  logic [7:0] core_rdata_o;
  logic core_rvalid_o;
  logic push_i, pop_i;
  iasg_pkg::iasg_mem_req_t mem_o;
  logic [7:0] mem_rdata_i;
  logic stack_reset_o, irq_o;
  // bench state
  int errors = 0;
  int n_tests = 0;
  logic [31:0] rd;
  logic se, r;
  logic [15:0] p;
  logic [7:0] d, md;
  logic [7:0] offs [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};
  logic [15:0] corner [6] = '{16'h0002, 16'h1fff, 16'h2000, 16'h7fff, 16'h8000, 16'hffff};

  iasg_top dut (.clock_i(clock_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .core_req_i(core_req_i),
    .core_rdata_o(core_rdata_o), .core_rvalid_o(core_rvalid_o), .push_i(push_i),
    .pop_i(pop_i), .mem_o(mem_o), .mem_rdata_i(mem_rdata_i),
    .stack_reset_o(stack_reset_o), .irq_o(irq_o));

  // ----------------------------------------
  // clock and watchdog
  // ----------------------------------------
  initial begin
    clock_i = 1'h0;
    forever #5 clock_i = ~clock_i;
  end
  // the whole sequence needs well under 3000 cycles
  initial begin
    repeat (8000) @(posedge clock_i);
    errors++;
    tally_and_finish();
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // one apb transfer; the request stands until pready is seen high or 50 cycles have passed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clock_i);
    psel_i <= 1'h1;
    penable_i <= 1'h0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge clock_i);
    penable_i <= 1'h1;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready_o !== 1'h1 && n < 50);
    if (n >= 50) errors++;
    rd = prdata_o;
    se = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(rd, exp, "register read");
  endtask : rdchk

  // drive one indirect access; returns at the middle of its cycle
  task automatic core(input logic s, input logic w, input logic [7:0] wd, input logic [7:0] m);
    @(posedge clock_i);
    core_req_i <= '{1'h1, s, w, wd};
    mem_rdata_i <= m;
    @(negedge clock_i);
  endtask : core

  // release the request; memory data no longer holds its value
  task automatic core_done();
    @(posedge clock_i);
    core_req_i.valid <= 1'h0;
    mem_rdata_i <= ~mem_rdata_i;
    @(negedge clock_i);
  endtask : core_done

  // one push or pop pulse, then the fault reset output one edge later
  task automatic stk(input logic psh);
    @(posedge clock_i);
    push_i <= psh;
    pop_i <= ~psh;
    @(posedge clock_i);
    push_i <= 1'h0;
    pop_i <= 1'h0;
    @(negedge clock_i);
    r = stack_reset_o;
  endtask : stk

  function automatic iasg_pkg::iasg_region_t exp_region(input logic [15:0] a);
    if (a < `IASG_LINEAR_BASE) return iasg_pkg::IASG_REG_BANKED;
    if (a < `IASG_FLASH_BASE) return iasg_pkg::IASG_REG_LINEAR;
    return iasg_pkg::IASG_REG_FLASH;
  endfunction : exp_region

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    reset_i = 1'h1;
    {psel_i, penable_i, pwrite_i, push_i, pop_i} = 5'h00;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    core_req_i = '0;
    mem_rdata_i = 8'h00;
    void'($urandom(29012));
    repeat (4) @(posedge clock_i);
    reset_i <= 1'h0;
    // every readable register up to the status starts at zero
    foreach (offs[k]) rdchk(offs[k], 32'h0);
    // unmapped place is refused and reads zero
    apb(1'h0, 8'h28, 32'h0);
    chk(se, 1'h1, "slave error");
    chk(rd, 32'h0, "unmapped data");
    // corners first, then random pointers on alternating channels
    for (int i = 0; i < 30; i++) begin
      p = (i < 6) ? corner[i] : 16'($urandom_range(16'hffff, 16'h0002));
      d = 8'($urandom);
      md = 8'($urandom);
      apb(1'h1, i[0] ? `IASG_OFF_PTR1_LO : `IASG_OFF_PTR0_LO, {24'h0, p[7:0]});
      apb(1'h1, i[0] ? `IASG_OFF_PTR1_HI : `IASG_OFF_PTR0_HI, {24'h0, p[15:8]});
      core(i[0], i[1], d, md);
      chk(mem_o.req, 1'h1, "redirected request");
      chk(mem_o.we, i[1], "redirected direction");
      chk(mem_o.addr, p, "pointer address");
      chk(mem_o.region, exp_region(p), "region");
      if (i[1]) chk(mem_o.wdata, d, "write data");
      core_done();
      if (!i[1]) chk(core_rvalid_o, 1'h1, "read valid");
      if (!i[1]) chk(core_rdata_o, md, "read data");
    end
    // the last pointer written stays readable byte by byte
    rdchk(`IASG_OFF_PTR1_LO, {24'h0, p[7:0]});
    rdchk(`IASG_OFF_PTR1_HI, {24'h0, p[15:8]});
    // pointer aimed at either port: write dropped, read zero
    for (int k = 0; k < 4; k++) begin
      apb(1'h1, k[0] ? `IASG_OFF_PTR1_LO : `IASG_OFF_PTR0_LO, {31'h0, k[1]});
      apb(1'h1, k[0] ? `IASG_OFF_PTR1_HI : `IASG_OFF_PTR0_HI, 32'h0);
      core(k[0], 1'h1, 8'hff, 8'h5a);
      chk({mem_o.req, mem_o.we}, 2'h0, "self write blocked");
      core_done();
      core(k[0], 1'h0, 8'h00, 8'ha5);
      core_done();
      chk(core_rdata_o, 8'h00, "self read zero");
    end
    // self access event is sticky; raise, then clear the interrupt
    rdchk(`IASG_OFF_ISTAT, 32'h4);
    apb(1'h1, `IASG_OFF_IEN, 32'h4);
    @(negedge clock_i);
    chk(irq_o, 1'h1, "irq raised");
    apb(1'h1, `IASG_OFF_ICLR, 32'h4);
    @(negedge clock_i);
    chk(irq_o, 1'h0, "irq cleared");
    // guard enabled: sixteen pushes fit, the next one resets
    apb(1'h1, `IASG_OFF_CFG, 32'h1);
    for (int k = 0; k < 16; k++) begin
      stk(1'h1);
      chk(r, 1'h0, "no fault reset");
    end
    rdchk(`IASG_OFF_DEPTH, 32'h10);
    stk(1'h1);
    chk(r, 1'h1, "overflow reset");
    rdchk(`IASG_OFF_PWR, 32'h1);
    rdchk(`IASG_OFF_DEPTH, 32'h0);
    stk(1'h0);
    chk(r, 1'h1, "underflow reset");
    rdchk(`IASG_OFF_PWR, 32'h3);
    // masked flags keep the interrupt low, enabled ones raise it
    apb(1'h1, `IASG_OFF_IEN, 32'h0);
    @(negedge clock_i);
    chk(irq_o, 1'h0, "irq masked");
    apb(1'h1, `IASG_OFF_IEN, 32'h3);
    @(negedge clock_i);
    chk(irq_o, 1'h1, "irq stack");
    apb(1'h1, `IASG_OFF_ICLR, 32'h3);
    apb(1'h1, `IASG_OFF_PWR, 32'h3);
    rdchk(`IASG_OFF_PWR, 32'h0);
    @(negedge clock_i);
    chk(irq_o, 1'h0, "irq stack cleared");
    // guard disabled: flag only, no reset, depth kept
    apb(1'h1, `IASG_OFF_CFG, 32'h0);
    stk(1'h0);
    chk(r, 1'h0, "disabled underflow");
    rdchk(`IASG_OFF_PWR, 32'h2);
    stk(1'h1);
    stk(1'h1);
    rdchk(`IASG_OFF_DEPTH, 32'h2);
    // a pop inside the stack only lowers the depth
    stk(1'h0);
    chk(r, 1'h0, "in-range pop");
    rdchk(`IASG_OFF_DEPTH, 32'h1);
    tally_and_finish();
  end
endmodule : iasg_bench
